/* File: hdl/osc_select_params.svh */
`ifndef OSC_SELECT_PARAMS_SVH
`define OSC_SELECT_PARAMS_SVH

// Register byte offsets
`define OFS_OSC_CONTROL       8'h00
`define OFS_CLOCK_DIVISOR     8'h04
`define OFS_PLL_FEEDBACK      8'h08
`define OFS_RC_TUNING         8'h0C

// Oscillator control fields
`define CUR_SRC_LSB           12
`define NEXT_SRC_LSB          8
`define FREEZE_BIT            7
`define REMAP_FREEZE_BIT      6
`define SETTLED_BIT           5
`define FAIL_BIT              3
`define LP_OSC_EN_BIT         1
`define SWITCH_REQ_BIT        0

// Clock divisor fields
`define RESTORE_BIT           15
`define REDUCTION_LSB         12
`define REDUCTION_EN_BIT      11
`define RC_POST_LSB           8
`define VCO_POST_LSB          6
`define VCO_PRE_LSB           0

// Reset values
`define RST_CLOCK_DIVISOR     16'h3040
`define RST_PLL_FEEDBACK      9'h030
`define RST_RC_TUNING         6'h00

// Switch timing, counted in edges of the new clock, and PLL feedback offset
`define NEW_CLK_SETTLE_EDGES  4'hA
`define PLL_OFFSET            10'h002

`endif

/* File: hdl/osc_select_pkg.sv */
package osc_select_pkg;

  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_READY = 2'b01,
    SW_COUNT = 2'b10
  } switch_state_e;

  // Configuration settings, static after power-on
  typedef struct packed {
    logic [2:0] initialSource;
    logic [1:0] switchMonitor;
    logic [1:0] primarySubmode;
  } config_s;

  // Divider settings handed to the clock tree
  typedef struct packed {
    logic [3:0] rcDivExp;
    logic [1:0] vcoPostExp;
    logic [5:0] vcoPreDiv;
    logic [9:0] feedbackMult;
    logic [5:0] rcTrim;
    logic [2:0] periphRatioExp;
  } divider_s;

endpackage

/* File: hdl/osc_select_regs.sv */
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "osc_select_params.svh"

module osc_select_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Configuration settings and processor events
  input  wire osc_select_pkg::config_s  cfg,
  input  wire logic                     interruptEvent,
  // Oscillator pins and monitors, asynchronous
  input  wire logic [7:0]               srcReady,
  input  wire logic                     pllLock,
  input  wire logic                     clockFail,
  input  wire logic                     newSrcClk,
  // Clock tree controls
  output logic [2:0]                    clkSel,
  output logic [2:0]                    startSel,
  output logic                          startReq,
  output logic                          secondaryOscEn,
  output logic                          pinRemapFreeze,
  output logic [1:0]                    primarySubmode,
  output osc_select_pkg::divider_s      dividers
);

  // Synchroniser: bit 0 new clock, 1 fail, 2 lock, 10:3 ready
  logic [10:0] syncA;
  logic [10:0] syncB;
  logic [10:0] syncC;
  logic [10:0] syncQ;
  wire  [10:0] syncIn = {srcReady, pllLock, clockFail, newSrcClk};
  wire  [10:0] syncAgree = ~(syncB ^ syncC);
  // Output moves only once the last two stages agree
  wire  [10:0] next_syncQ = (syncB & syncAgree) | (syncQ & ~syncAgree);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 11'h000;
      syncB <= 11'h000;
      syncC <= 11'h000;
      syncQ <= 11'h000;
    end
    else
    begin
      syncA <= syncIn;
      syncB <= syncA;
      syncC <= syncB;
      syncQ <= next_syncQ;
    end
  end

  wire       newClkQ  = syncQ[0];
  wire       failQ    = syncQ[1];
  wire       lockQ    = syncQ[2];
  wire [7:0] readyQ   = syncQ[10:3];
  logic      newClkPrev;
  logic      failPrev;
  wire       newClkEdge = newClkQ & ~newClkPrev;
  wire       failEvent  = failQ & ~failPrev;

  // Register state
  logic                          loaded;
  logic [2:0]                    curSrc;
  logic [2:0]                    nextSrc;
  logic [2:0]                    target;
  logic                          freeze;
  logic                          settled;
  logic                          failFlag;
  logic                          switchReq;
  logic [15:0]                   clockDivisor;
  logic [8:0]                    feedback;
  logic [5:0]                    trim;
  logic [3:0]                    edgeCount;
  osc_select_pkg::switch_state_e state;

  // Bus decode
  wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wrEn     = access & wb_we_i;
  wire        wrLo     = wrEn & wb_sel_i[0];
  wire        wrHi     = wrEn & wb_sel_i[1];
  wire        hitCtl   = wb_adr_i == `OFS_OSC_CONTROL;
  wire        hitDiv   = wb_adr_i == `OFS_CLOCK_DIVISOR;
  wire        hitFbd   = wb_adr_i == `OFS_PLL_FEEDBACK;
  wire        hitTun   = wb_adr_i == `OFS_RC_TUNING;
  wire [15:0] wd       = wb_dat_i[15:0];

  // Switching permission from configuration
  // A frozen request stays pending, it is never dropped
  wire switchEnabled = ~cfg.switchMonitor[1];
  wire freezeApplies = cfg.switchMonitor == 2'b01;
  wire switchAllowed = switchEnabled & ~(freezeApplies & freeze);
  wire reqWrite = wrLo & hitCtl & wd[`SWITCH_REQ_BIT];
  wire usesPll = (target == 3'h1) | (target == 3'h3);

  // Switch sequencer decisions
  wire startReqd = (state == osc_select_pkg::SW_IDLE) & switchReq & switchAllowed;
  wire redundant = startReqd & (curSrc == nextSrc);
  wire validStart = startReqd & ~redundant;
  wire srcGood = readyQ[target] & (~usesPll | lockQ);
  wire lastEdge = newClkEdge & (edgeCount == `NEW_CLK_SETTLE_EDGES - 4'h1);
  wire switchDone = (state == osc_select_pkg::SW_COUNT) & lastEdge;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= osc_select_pkg::SW_IDLE;
    else
    begin
      unique case (state)
        osc_select_pkg::SW_IDLE:
          if (validStart)
            state <= osc_select_pkg::SW_READY;
        osc_select_pkg::SW_READY:
          if (srcGood)
            state <= osc_select_pkg::SW_COUNT;
        osc_select_pkg::SW_COUNT:
          if (switchDone)
            state <= osc_select_pkg::SW_IDLE;
        default:
          state <= osc_select_pkg::SW_IDLE;
      endcase
    end
  end

  // Edges of the new clock counted only once it is ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edgeCount  <= 4'h0;
      newClkPrev <= 1'b0;
      failPrev   <= 1'b0;
    end
    else
    begin
      newClkPrev <= newClkQ;
      failPrev   <= failQ;
      if (state != osc_select_pkg::SW_COUNT)
        edgeCount <= 4'h0;
      else if (newClkEdge)
        edgeCount <= edgeCount + 4'h1;
    end
  end

  // Source selection; straps taken on the first edge after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loaded         <= 1'b0;
      curSrc         <= 3'h0;
      nextSrc        <= 3'h0;
      target         <= 3'h0;
      clkSel         <= 3'h0;
      primarySubmode <= 2'h0;
    end
    else if (!loaded)
    begin
      loaded         <= 1'b1;
      curSrc         <= cfg.initialSource;
      nextSrc        <= cfg.initialSource;
      target         <= cfg.initialSource;
      clkSel         <= cfg.initialSource;
      primarySubmode <= cfg.primarySubmode;
    end
    else
    begin
      if (wrHi && hitCtl)
        nextSrc <= wd[`NEXT_SRC_LSB +: 3];
      if (validStart)
        target <= nextSrc;
      if (switchDone)
      begin
        curSrc <= target;
        clkSel <= target;
      end
    end
  end

  // Oscillator start request toward the clock tree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startReq <= 1'b0;
      startSel <= 3'h0;
    end
    else
    begin
      if (validStart)
      begin
        startReq <= 1'b1;
        startSel <= nextSrc;
      end
      else if (switchDone)
        startReq <= 1'b0;
    end
  end

  // Request bit: a new write beats the completion clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      switchReq <= 1'b0;
    else if (!switchEnabled)
      switchReq <= 1'b0;
    else if (reqWrite)
      switchReq <= 1'b1;
    else if (redundant || switchDone)
      switchReq <= 1'b0;
  end

  // Status flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settled  <= 1'b0;
      failFlag <= 1'b0;
    end
    else
    begin
      settled <= lockQ & ~validStart;
      // Monitor set wins over a same-cycle clear
      if (failEvent)
        failFlag <= 1'b1;
      else if (validStart)
        failFlag <= 1'b0;
      else if (wrLo && hitCtl && !wd[`FAIL_BIT])
        failFlag <= 1'b0;
    end
  end

  // Control bits of the oscillator register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freeze         <= 1'b0;
      pinRemapFreeze <= 1'b0;
      secondaryOscEn <= 1'b0;
    end
    else if (wrLo && hitCtl)
    begin
      freeze         <= freeze | wd[`FREEZE_BIT];
      pinRemapFreeze <= wd[`REMAP_FREEZE_BIT];
      secondaryOscEn <= wd[`LP_OSC_EN_BIT];
    end
  end

  // Divisor, feedback and trim registers
  wire irqRestore = interruptEvent & clockDivisor[`RESTORE_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clockDivisor <= `RST_CLOCK_DIVISOR;
      feedback     <= `RST_PLL_FEEDBACK;
      trim         <= `RST_RC_TUNING;
    end
    else
    begin
      if (wrLo && hitDiv)
        clockDivisor[7:0] <= wd[7:0] & 8'hDF;
      if (wrHi && hitDiv)
        clockDivisor[15:8] <= wd[15:8];
      // Last, so the interrupt beats a same-cycle write
      if (irqRestore)
        clockDivisor[`REDUCTION_EN_BIT] <= 1'b0;
      if (wrLo && hitFbd)
        feedback[7:0] <= wd[7:0];
      if (wrHi && hitFbd)
        feedback[8] <= wd[8];
      if (wrLo && hitTun)
        trim <= wd[5:0];
    end
  end

  // Decoded divider settings for the clock tree
  wire [2:0] rcCode   = clockDivisor[`RC_POST_LSB +: 3];
  wire [1:0] postCode = clockDivisor[`VCO_POST_LSB +: 2];
  wire [4:0] preCode  = clockDivisor[`VCO_PRE_LSB +: 5];
  wire [2:0] reduce   = clockDivisor[`REDUCTION_LSB +: 3];
  wire       reduceOn = clockDivisor[`REDUCTION_EN_BIT];
  // Reserved post code holds the previous divide, never a bogus one
  wire [1:0] next_post = (postCode == 2'b00) ? 2'h1 :
                         (postCode == 2'b01) ? 2'h2 :
                         (postCode == 2'b11) ? 2'h3 : dividers.vcoPostExp;
  osc_select_pkg::divider_s next_div;

  assign next_div.rcDivExp = (rcCode == 3'h7) ? 4'h8 : {1'b0, rcCode};
  assign next_div.vcoPostExp = next_post;
  assign next_div.vcoPreDiv = {1'b0, preCode} + 6'h02;
  assign next_div.feedbackMult = {1'b0, feedback} + `PLL_OFFSET;
  assign next_div.rcTrim = trim;
  assign next_div.periphRatioExp = reduceOn ? reduce : 3'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dividers <= '{rcDivExp: 4'h0, vcoPostExp: 2'h2, vcoPreDiv: 6'h02,
                    feedbackMult: 10'h032, rcTrim: 6'h00, periphRatioExp: 3'h0};
    else
      dividers <= next_div;
  end

  // Read mux; unimplemented bits and unmapped addresses read zero
  wire [15:0] ctlRead = {1'b0, curSrc, 1'b0, nextSrc, freeze, pinRemapFreeze,
                         settled, 1'b0, failFlag, 1'b0, secondaryOscEn,
                         switchReq};
  wire [15:0] rdSel = hitCtl ? ctlRead :
                      hitDiv ? clockDivisor :
                      hitFbd ? {7'h00, feedback} :
                      hitTun ? {10'h000, trim} : 16'h0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= access;
      wb_dat_o <= access ? {16'h0000, rdSel} : 32'h0000_0000;
    end
  end

endmodule

/* File: bench/osc_select_regs_sva.sv */
`timescale 1ns/1ns
module osc_select_regs_sva (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Switch control and clock tree
  input wire osc_select_pkg::config_s  cfg,
  input wire logic [2:0]  clkSel,
  input wire logic [2:0]  startSel,
  input wire logic        startReq,
  input wire osc_select_pkg::divider_s dividers
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Field lands at the take edge, divider outputs one edge later
  sequence wr_take(logic [7:0] a);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == a && wb_sel_i[1:0] == 2'b11;
  endsequence
  sequence rd_unmapped;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > 8'h0C;
  endsequence

  unmapped_zero_a: assert property (rd_unmapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  pre_div_a: assert property (wr_take(8'h04) |=> ##1
    dividers.vcoPreDiv == $past(wb_dat_i[4:0], 2) + 6'h02) else $error("pre-divider wrong");
  feedback_mult_a: assert property (wr_take(8'h08) |=> ##1
    dividers.feedbackMult == {1'b0, $past(wb_dat_i[8:0], 2)} + 10'h002)
    else $error("multiplier wrong");
  rc_trim_a: assert property (wr_take(8'h0C) |=> ##1
    dividers.rcTrim == $past(wb_dat_i[5:0], 2)) else $error("trim wrong");
  switch_off_a: assert property (cfg.switchMonitor[1] |-> !startReq)
    else $error("switch started while disabled");
  start_sel_a: assert property ($rose(startReq) |-> startSel != clkSel)
    else $error("redundant switch started");
  done_copy_a: assert property ($fell(startReq) |-> clkSel == $past(startSel))
    else $error("switch ended on wrong source");
  clksel_hold_a: assert property ($past(rst_n, 2) && !$stable(clkSel) |-> $fell(startReq))
    else $error("select moved outside switch end");
endmodule

/* File: bench/tb_osc_select_regs.sv */
`timescale 1ns/1ns
bind osc_select_regs osc_select_regs_sva chk (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .cfg, .clkSel, .startSel, .startReq, .dividers
);

module tb_osc_select_regs;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     wb_cyc_i = 1'b0;
  logic                     wb_stb_i = 1'b0;
  logic                     wb_we_i = 1'b0;
  logic [7:0]               wb_adr_i = 8'h00;
  logic [3:0]               wb_sel_i = 4'h0;
  logic [3:0]               laneSel = 4'h3;
  logic [31:0]              wb_dat_i = 32'h0;
  logic [31:0]              wb_dat_o;
  logic                     wb_ack_o;
  osc_select_pkg::config_s  cfg = '{3'h2, 2'h1, 2'h2};
  logic                     interruptEvent = 1'b0;
  logic [7:0]               srcReady = 8'h00;
  logic                     pllLock = 1'b0;
  logic                     clockFail = 1'b0;
  logic                     newSrcClk = 1'b0;
  logic [2:0]               clkSel;
  logic [2:0]               startSel;
  logic                     startReq;
  logic                     secondaryOscEn;
  logic                     pinRemapFreeze;
  logic [1:0]               primarySubmode;
  osc_select_pkg::divider_s dividers;
  logic [15:0]              expQ[$];
  logic [15:0]              mask[5] = '{16'h0, 16'hFFDF, 16'h01FF, 16'h003F, 16'h0};
  logic [31:0]              seed = 32'hFB547B67;
  int                       num_errors = 0;
  int                       samples_checked = 0;

  osc_select_regs dut (
    .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cfg, .interruptEvent, .srcReady, .pllLock, .clockFail, .newSrcClk,
    .clkSel, .startSel, .startReq, .secondaryOscEn, .pinRemapFreeze, .primarySubmode, .dividers
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic fail_out;
    num_errors++;
    summarize();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= laneSel;
    wb_dat_i <= {16'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
      fail_out();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 16'h0);
  endtask

  // Read data is judged where ack appears, against the oldest note
  always @(posedge clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, {16'h0, expQ.size() > 0 ? expQ.pop_front() : 16'hFFFF});

  task automatic sw(input logic [2:0] t, input logic l);
    logic [2:0] old;
    int n;
    old = clkSel;
    srcReady[t] <= 1'b1;
    pllLock <= l;
    bus(1'b1, 8'h00, {5'h0, t, 8'h01});
    for (n = 0; n < 20 && startReq !== 1'b1; n++)
      @(posedge clk);
    if (n >= 20)
      fail_out();
    check(32'(startSel), 32'(t));
    // Ready and lock pass a synchronizer first
    repeat (10) @(posedge clk);
    // Three-cycle phases survive the agree filter on the pin
    for (n = 0; n < 10; n++)
    begin
      repeat (3) @(posedge clk);
      newSrcClk <= 1'b1;
      repeat (3) @(posedge clk);
      newSrcClk <= 1'b0;
      if (n == 8)
      begin
        repeat (4) @(posedge clk);
        check(32'(clkSel), 32'(old));
      end
    end
    for (n = 0; n < 20 && startReq === 1'b1; n++)
      @(posedge clk);
    if (n >= 20)
      fail_out();
    check(32'({startReq, clkSel}), 32'(t));
    rd(8'h00, {1'b0, t, 1'b0, t, 2'h0, l, 5'h0});
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h00, 16'h2200);
    rd(8'h04, 16'h3040);
    rd(8'h08, 16'h0030);
    repeat (3)
      for (int i = 1; i < 5; i++)
      begin
        seed = lfsr(seed);
        bus(1'b1, 8'(4 * i), seed[15:0]);
        rd(8'(4 * i), seed[15:0] & mask[i]);
      end
    bus(1'b1, 8'h08, 16'h01FF);
    bus(1'b1, 8'h0C, 16'h0020);
    bus(1'b1, 8'h04, 16'hB9C5);
    repeat (2) @(posedge clk);
    // Post /8, pre /7, multiplier 513, trim -12 percent, ratio /8
    check(32'(dividers), 32'h0E3C0303);
    interruptEvent <= 1'b1;
    @(posedge clk);
    interruptEvent <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(dividers.periphRatioExp), 32'h0);
    rd(8'h04, 16'hB1C5);
    // Single-lane writes touch only their own byte
    laneSel = 4'h1;
    bus(1'b1, 8'h08, 16'h0000);
    laneSel = 4'h2;
    bus(1'b1, 8'h0C, 16'h003F);
    laneSel = 4'h3;
    rd(8'h08, 16'h0100);
    rd(8'h0C, 16'h0020);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'h04, {1'b0, 3'(c), 1'b1, 3'(c), 8'h40});
      repeat (2) @(posedge clk);
      check(32'({dividers.rcDivExp, dividers.periphRatioExp}),
        32'({c == 7 ? 4'h8 : 4'(c), 3'(c)}));
    end
    // Restore bit clear: interrupt leaves the ratio alone
    interruptEvent <= 1'b1;
    @(posedge clk);
    interruptEvent <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(dividers.periphRatioExp), 32'h7);
    clockFail <= 1'b1;
    repeat (6) @(posedge clk);
    clockFail <= 1'b0;
    rd(8'h00, 16'h2208);
    sw(3'h4, 1'b0);
    bus(1'b1, 8'h00, 16'h0401);
    rd(8'h00, 16'h4400);
    check(32'(startReq), 32'h0);
    sw(3'h1, 1'b1);
    clockFail <= 1'b1;
    repeat (6) @(posedge clk);
    clockFail <= 1'b0;
    rd(8'h00, 16'h1128);
    bus(1'b1, 8'h00, 16'h1142);
    rd(8'h00, 16'h1162);
    check(32'({pinRemapFreeze, secondaryOscEn}), 32'h3);
    bus(1'b1, 8'h00, 16'h1180);
    bus(1'b1, 8'h00, 16'h1100);
    rd(8'h00, 16'h11A0);
    bus(1'b1, 8'h00, 16'h1081);
    repeat (30) @(posedge clk);
    check(32'({startReq, clkSel}), 32'h1);
    // Switching disabled by configuration after a fresh reset
    cfg <= '{3'h5, 2'h2, 2'h1};
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b1, 8'h00, 16'h0201);
    rd(8'h00, 16'h5220);
    check(32'({primarySubmode, clkSel}), 32'h0D);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
